// File: sirq_dev.sv
// Device end of the serial interrupt link; link side on the link clock, level capture and status on the system clock.
// Assumes sources and routing come from the system clock domain; routing is
// held steady by software while the link runs, so it is crossed as levels.
module sirq_dev
    import sirq_pkg::*;
#(
    parameter int NSRC = SIRQ_NSRC
) (
    sirq_if.dev lnk,
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [NSRC-1:0] i_src_irq,
    input wire logic [SIRQ_NFRAMES*SIRQ_ROUTE_W-1:0] i_route,
    input wire logic i_smi_level,
    input wire logic i_smi_event_mask,
    output logic o_quiet,
    output logic o_active
);
    typedef enum logic [1:0] {SIRQD_IDLE, SIRQD_START, SIRQD_DATA, SIRQD_STOP} sirqd_state_t;

    // ==========================================================================
    // Routing entry fields
    function automatic logic sirqd_route_en(
        input logic [SIRQ_NFRAMES*SIRQ_ROUTE_W-1:0] r,
        input int f
    );
        sirqd_route_en = r[f*SIRQ_ROUTE_W + SIRQ_ROUTE_EN_BIT];
    endfunction : sirqd_route_en

    function automatic logic [SIRQ_SRC_W-1:0] sirqd_route_src(
        input logic [SIRQ_NFRAMES*SIRQ_ROUTE_W-1:0] r,
        input int f
    );
        sirqd_route_src = r[f*SIRQ_ROUTE_W +: SIRQ_SRC_W];
    endfunction : sirqd_route_src

    // ==========================================================================
    // System-domain capture of the frame levels
    logic [SIRQ_NFRAMES-1:0] lvl_sys_q;
    logic [SIRQ_NFRAMES-1:0] lvl_sys_d;
    logic [SIRQ_NFRAMES-1:0] lvl_l;
    logic [SIRQ_NFRAMES-1:0] last_sent_q;
    logic [SIRQ_NFRAMES-1:0] sent_d;
    wire smi_slot_free = !sirqd_route_en(i_route, SIRQ_SMI_FRAME) && !i_smi_event_mask;

    always_comb begin
        lvl_sys_d = '1;
        for (int f = 0; f < SIRQ_NFRAMES; f++) begin
            // Disabled entry leaves frame released
            if (sirqd_route_en(i_route, f))
                lvl_sys_d[f] = i_src_irq[sirqd_route_src(i_route, f)];
        end
        // Management irq only if routing leaves frame 2 unused
        if (smi_slot_free)
            lvl_sys_d[SIRQ_SMI_FRAME] = i_smi_level;
        // First frame carries nothing
        lvl_sys_d[0] = 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst)
            lvl_sys_q <= '1;
        else
            lvl_sys_q <= lvl_sys_d;
    end

    // Inverted so the cleared syncs read as all levels high after reset
    sirq_sync #(.W(SIRQ_NFRAMES)) u_lvl_sync (
        .i_clk(lnk.i_lclk),
        .i_nrst(lnk.i_nrst),
        .i_d(~lvl_sys_q),
        .o_q(sent_d)
    );
    assign lvl_l = ~sent_d;

    // ==========================================================================
    // Link-side tracking
    sirqd_state_t st_q;
    logic [SIRQ_CNT_W-1:0] cnt_q;
    logic [SIRQ_CNT_W-1:0] low_q;
    logic line_d1_q;
    logic quiet_q;
    logic [1:0] gap_q;
    logic oe_q;
    logic o_q;
    logic drove_q;

    wire line = lnk.line;
    wire rise = line && !line_d1_q;
    wire changed = |(lvl_l ^ last_sent_q);
    // Frame position of the clock after this edge, index cnt_q+1
    wire [1:0] phase = 2'((cnt_q + 6'h01) % 6'(SIRQ_FRAME_CLKS));
    wire [SIRQ_CNT_W-1:0] fidx_w = 6'((cnt_q + 6'h01) / 6'(SIRQ_FRAME_CLKS));
    wire [3:0] fnum = fidx_w[3:0];
    wire in_frames = cnt_q < 6'(SIRQ_LAST_SAMPLE + 2);
    // Next clock is the sample clock of a frame whose captured level is low
    wire slot_low = in_frames && phase == 2'(SIRQ_FRAME_CLKS - 1) && fnum != 4'h0 && !last_sent_q[fnum];
    // Only the idle state may start a cycle, never a running one
    wire can_start = st_q == SIRQD_IDLE && quiet_q && gap_q == 2'h0 && !oe_q && line;

    always_ff @(posedge lnk.i_lclk or negedge lnk.i_nrst) begin
        if (!lnk.i_nrst) begin
            st_q <= SIRQD_IDLE;
            cnt_q <= 6'h00;
            low_q <= 6'h00;
            line_d1_q <= 1'b1;
            quiet_q <= 1'b0;
            gap_q <= 2'h0;
            oe_q <= 1'b0;
            o_q <= 1'b0;
            drove_q <= 1'b0;
            last_sent_q <= '1;
        end else begin
            line_d1_q <= line;
            // No saturation: a legal low never exceeds eight clocks
            low_q <= line ? 6'h00 : low_q + 6'h01;
            if (gap_q != 2'h0)
                gap_q <= gap_q - 2'h1;
            oe_q <= 1'b0;
            o_q <= 1'b0;
            drove_q <= 1'b0;
            unique case (st_q)
                SIRQD_IDLE: begin
                    if (!line) begin
                        // Levels frozen here; a change during the cycle waits
                        // for the next one, even if its frame is still ahead
                        st_q <= SIRQD_START;
                        last_sent_q <= lvl_l;
                    end else if (can_start && changed) begin
                        oe_q <= 1'b1; // one low clock, never high
                    end
                end
                SIRQD_START: begin
                    if (rise) begin
                        st_q <= SIRQD_DATA;
                        cnt_q <= 6'h01;
                    end
                end
                SIRQD_DATA: begin
                    cnt_q <= cnt_q + 6'h01;
                    // Drive for the clock after this edge, index cnt_q+1
                    if (slot_low) begin
                        oe_q <= 1'b1;
                    end else if (drove_q) begin
                        oe_q <= 1'b1; // recovery high
                        o_q <= 1'b1;
                    end
                    if (!in_frames && !line)
                        st_q <= SIRQD_STOP;
                end
                SIRQD_STOP: begin
                    if (rise) begin
                        st_q <= SIRQD_IDLE;
                        quiet_q <= low_q == 6'(SIRQ_STOP_QUIET);
                        // Earliest legal start is two clocks past the stop rise
                        gap_q <= 2'(SIRQ_IDLE_GAP - 1);
                    end
                end
            endcase
            if (st_q == SIRQD_DATA && slot_low)
                drove_q <= 1'b1;
        end
    end

    assign lnk.dev_oe = oe_q;
    assign lnk.dev_o = o_q;

    // ==========================================================================
    // Status back to the system clock
    // Two slow independent flags, so a plain two-flop crossing suffices
    logic [1:0] stat_s;
    sirq_sync #(.W(2)) u_stat_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d({quiet_q, st_q != SIRQD_IDLE}),
        .o_q(stat_s)
    );
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_quiet <= 1'b0;
            o_active <= 1'b0;
        end else begin
            o_quiet <= stat_s[1];
            o_active <= stat_s[0];
        end
    end
endmodule : sirq_dev

// File: sirq_host.sv
// Host end of the serial interrupt link; makes the link clock by division.
// Assumes the bench ties the interface clock to o_lclk.
module sirq_host
    import sirq_pkg::*;
#(
    parameter int DIV = 2,
    parameter int START_LOW = SIRQ_START_MIN
) (
    sirq_if.host lnk,
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_run,
    input wire logic i_quiet_next,
    output logic o_lclk,
    output logic [SIRQ_NFRAMES-1:0] o_irq_low,
    output logic o_done
);
    typedef enum logic [2:0] {SIRQH_IDLE, SIRQH_START, SIRQH_HIGH, SIRQH_DATA, SIRQH_STOP, SIRQH_SHIGH} sirqh_state_t;

    // ==========================================================================
    // Link clock divider
    logic [7:0] div_q;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div_q <= 8'h00;
            o_lclk <= 1'b0;
        end else if (div_q == 8'(DIV - 1)) begin
            div_q <= 8'h00;
            o_lclk <= !o_lclk;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // ==========================================================================
    // Link side
    logic [1:0] ctl_l;
    sirq_sync #(.W(2)) u_ctl_sync (
        .i_clk(lnk.i_lclk),
        .i_nrst(lnk.i_nrst),
        .i_d({i_run, i_quiet_next}),
        .o_q(ctl_l)
    );

    sirqh_state_t st_q;
    logic [SIRQ_CNT_W-1:0] cnt_q;
    logic [SIRQ_NFRAMES-1:0] cap_q;
    logic quiet_q;
    logic done_tgl_q;
    logic oe_q;
    logic o_q;

    always_ff @(posedge lnk.i_lclk or negedge lnk.i_nrst) begin
        if (!lnk.i_nrst) begin
            st_q <= SIRQH_IDLE;
            cnt_q <= 6'h00;
            cap_q <= '1;
            quiet_q <= 1'b0;
            done_tgl_q <= 1'b0;
            oe_q <= 1'b0;
            o_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 6'h01;
            unique case (st_q)
                SIRQH_IDLE: begin
                    // Continuous: host starts; quiet: device low also starts
                    if (ctl_l[1] || (quiet_q && !lnk.line)) begin
                        st_q <= SIRQH_START;
                        oe_q <= 1'b1;
                        o_q <= 1'b0;
                        cnt_q <= quiet_q && !lnk.line ? 6'h02 : 6'h01;
                    end
                end
                SIRQH_START: begin
                    if (cnt_q >= 6'(START_LOW)) begin
                        st_q <= SIRQH_HIGH;
                        o_q <= 1'b1;
                    end
                end
                SIRQH_HIGH: begin
                    st_q <= SIRQH_DATA;
                    oe_q <= 1'b0;
                    cnt_q <= 6'h01;
                end
                SIRQH_DATA: begin
                    if (cnt_q % 6'(SIRQ_FRAME_CLKS) == 6'(SIRQ_FRAME_CLKS - SIRQ_SAMPLE_OFS))
                        cap_q[4'(cnt_q / 6'(SIRQ_FRAME_CLKS))] <= !lnk.line;
                    if (cnt_q == 6'(SIRQ_LAST_SAMPLE + 2)) begin
                        st_q <= SIRQH_STOP;
                        oe_q <= 1'b1;
                        o_q <= 1'b0;
                        cnt_q <= 6'h01;
                        quiet_q <= ctl_l[0];
                    end
                end
                SIRQH_STOP: begin
                    if (cnt_q >= 6'(quiet_q ? SIRQ_STOP_QUIET : SIRQ_STOP_CONT)) begin
                        st_q <= SIRQH_SHIGH;
                        o_q <= 1'b1;
                    end
                end
                SIRQH_SHIGH: begin
                    st_q <= SIRQH_IDLE;
                    oe_q <= 1'b0;
                    done_tgl_q <= !done_tgl_q;
                end
                default: st_q <= SIRQH_IDLE;
            endcase
        end
    end

    assign lnk.host_oe = oe_q;
    assign lnk.host_o = o_q;

    // ==========================================================================
    // Result back to system clock; captured frames are stable after the toggle
    logic done_s;
    logic done_s_d1_q;
    sirq_sync #(.W(1)) u_done_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d(done_tgl_q),
        .o_q(done_s)
    );
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            done_s_d1_q <= 1'b0;
            o_done <= 1'b0;
            o_irq_low <= '0;
        end else begin
            done_s_d1_q <= done_s;
            o_done <= done_s ^ done_s_d1_q;
            if (done_s ^ done_s_d1_q)
                o_irq_low <= cap_q;
        end
    end
endmodule : sirq_host

// File: sirq_if.sv
// Shared serial interrupt wire, resolved from the enables of both ends.
// Assumes a pull-up: an undriven line reads high.
interface sirq_if (
    input wire logic i_lclk,
    input wire logic i_nrst
);
    logic host_oe;
    logic host_o;
    logic dev_oe;
    logic dev_o;
    logic line;
    assign line = (host_oe && !host_o) || (dev_oe && !dev_o) ? 1'b0 : 1'b1;

    modport host (input i_lclk, input i_nrst, input line, output host_oe, output host_o);
    modport dev (input i_lclk, input i_nrst, input line, output dev_oe, output dev_o);
endinterface : sirq_if

// File: sirq_link_chk.sv
// Checker on the shared serial interrupt wire: framing, device drive phases, widths.
// Assumes the plain signals of the link interface, sampled on the link clock except by the reset check at release.
module sirq_link_chk
    import sirq_pkg::*;
(
    input wire logic i_lclk,
    input wire logic i_nrst,
    input wire logic host_oe,
    input wire logic host_o,
    input wire logic dev_oe,
    input wire logic dev_o,
    input wire logic line
);
    // ==========================================================================
    // Frame tracking from the wire alone
    logic [3:0] low_q;
    logic [5:0] pos_q;
    logic [1:0] gap_q;
    logic act_q;
    logic quiet_q;
    wire rise = line && (low_q != 4'h0);
    // Frame 16's own low ends at clock 48, so only a later rise can end a stop
    wire stop_rise = rise && act_q && (pos_q > 6'(SIRQ_LAST_SAMPLE + 1));
    wire start_rise = rise && !act_q && (low_q >= 4'(SIRQ_START_MIN));
    wire dev_low = dev_oe && !dev_o;
    wire in_sample = ((pos_q % 6'h03) == 6'h02) && (pos_q >= 6'h05) && (pos_q <= 6'(SIRQ_LAST_SAMPLE));
    wire [3:0] low_d = line ? 4'h0 : (low_q == 4'hf ? low_q : low_q + 4'h1);
    wire [5:0] pos_d = start_rise ? 6'h01 : ((act_q && pos_q != 6'h3f) ? pos_q + 6'h01 : pos_q);
    wire [1:0] gap_d = stop_rise ? 2'h1 : ((!act_q && gap_q != 2'h3) ? gap_q + 2'h1 : gap_q);
    wire act_d = start_rise ? 1'b1 : (stop_rise ? 1'b0 : act_q);
    wire quiet_d = stop_rise ? (low_q == 4'(SIRQ_STOP_QUIET)) : quiet_q;

    always_ff @(posedge i_lclk or negedge i_nrst) begin
        if (!i_nrst) begin
            low_q <= 4'h0;
            pos_q <= 6'h00;
            gap_q <= 2'h0;
            act_q <= 1'b0;
            quiet_q <= 1'b0;
        end else begin
            low_q <= low_d;
            pos_q <= pos_d;
            gap_q <= gap_d;
            act_q <= act_d;
            quiet_q <= quiet_d;
        end
    end

    // ==========================================================================
    // Properties
    sequence dev_high_s;
        dev_oe && dev_o;
    endsequence
    sequence dev_free_s;
        !dev_oe;
    endsequence
    default clocking cb @(posedge i_lclk); endclocking
    default disable iff (!i_nrst);

    // The link clock stops in reset, so check the drives held up to release
    reset_release_a: assert property (@(posedge i_nrst) disable iff (1'b0) !dev_oe && !host_oe)
        else $error("line driven during reset");
    recover_turn_a: assert property (dev_low && act_q |=> dev_high_s ##1 dev_free_s)
        else $error("recovery or turnaround wrong");
    sample_slot_a: assert property (dev_low && act_q |-> in_sample)
        else $error("device low outside a sample clock");
    start_single_a: assert property (dev_low && !act_q |=> dev_free_s)
        else $error("device start not one clock");
    start_permit_a: assert property (dev_low && !act_q |-> quiet_q && gap_q >= 2'(SIRQ_IDLE_GAP))
        else $error("device start not allowed here");
    high_after_low_a: assert property (dev_high_s |-> $past(dev_low))
        else $error("device high without own low");
    stop_silent_a: assert property (act_q && pos_q > 6'(SIRQ_LAST_SAMPLE + 1) |-> !dev_oe)
        else $error("device drives during stop");
    start_width_a: assert property (rise && !act_q |-> low_q >= 4'(SIRQ_START_MIN) && low_q <= 4'(SIRQ_START_MAX))
        else $error("start width out of range");
    stop_width_a: assert property (stop_rise |-> low_q == 4'(SIRQ_STOP_QUIET) || low_q == 4'(SIRQ_STOP_CONT))
        else $error("stop width out of range");
    host_release_a: assert property (host_oe && host_o |=> !host_oe)
        else $error("host high longer than one clock");
endmodule : sirq_link_chk

// File: sirq_pkg.sv
// Shared constants for the serial interrupt link: frame timing, pulse widths,
// routing field layout.
// Assumes both ends run their link logic on the rising edge of the link clock.
package sirq_pkg;
    // ==========================================================================
    // Frame layout
    localparam int SIRQ_NFRAMES = 16;
    localparam int SIRQ_FRAME_CLKS = 3;
    localparam int SIRQ_SAMPLE_OFS = 1;
    localparam int SIRQ_LAST_SAMPLE = SIRQ_NFRAMES * SIRQ_FRAME_CLKS - SIRQ_SAMPLE_OFS;
    // ==========================================================================
    // Pulse widths (link clocks)
    localparam int SIRQ_START_MIN = 4;
    localparam int SIRQ_START_MAX = 8;
    localparam int SIRQ_STOP_QUIET = 2;
    localparam int SIRQ_STOP_CONT = 3;
    localparam int SIRQ_IDLE_GAP = 2;
    // ==========================================================================
    // Routing entry: valid, source index
    localparam int SIRQ_NSRC = 32;
    localparam int SIRQ_SRC_W = 5;
    localparam int SIRQ_ROUTE_W = SIRQ_SRC_W + 1;
    localparam int SIRQ_ROUTE_EN_BIT = SIRQ_SRC_W;
    localparam logic [SIRQ_ROUTE_W-1:0] SIRQ_ROUTE_RST = 6'h00;
    // Slot index of the third frame, the one that carries the management irq when unrouted
    localparam int SIRQ_SMI_FRAME = 2;
    // ==========================================================================
    // Counter width covering a whole cycle
    localparam int SIRQ_CNT_W = 6;

    // Clock index past the start rising edge at which frame n is sampled
    function automatic logic [SIRQ_CNT_W-1:0] sirq_sample_clk(input int n);
        sirq_sample_clk = SIRQ_CNT_W'(n * SIRQ_FRAME_CLKS - SIRQ_SAMPLE_OFS);
    endfunction : sirq_sample_clk
endpackage : sirq_pkg

// File: sirq_sync.sv
// Two-flop synchroniser for a bus of levels.
// Assumes the inputs are levels that hold for several destination clocks.
module sirq_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule : sirq_sync

// File: tb_serial_irq_slave_agent.sv
// Bench: host and device ends joined on one link, random routing and levels.
// Assumes the host divides the system clock to make the link clock.
module tb_serial_irq_slave_agent
    import sirq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, run, qn, smi, mask, done, done_q, quiet, active;
    logic [SIRQ_NSRC-1:0] src;
    logic [SIRQ_NFRAMES*SIRQ_ROUTE_W-1:0] route;
    logic [SIRQ_NFRAMES-1:0] irq_low;
    logic [31:0] seed;
    logic [15:0] exp_q[$];
    int mismatches;
    int num_checks;
    wire lclk;

    sirq_if i_sirq_if (.i_lclk(lclk), .i_nrst(nrst));
    sirq_host #(.DIV(2), .START_LOW(SIRQ_START_MIN)) i_sirq_host (.lnk(i_sirq_if), .i_clk(clk), .i_nrst(nrst),
        .i_run(run), .i_quiet_next(qn), .o_lclk(lclk), .o_irq_low(irq_low), .o_done(done));
    sirq_dev #(.NSRC(SIRQ_NSRC)) i_sirq_dev (.lnk(i_sirq_if), .i_clk(clk), .i_nrst(nrst), .i_src_irq(src),
        .i_route(route), .i_smi_level(smi), .i_smi_event_mask(mask), .o_quiet(quiet), .o_active(active));
    sirq_link_chk i_sirq_link_chk (.i_lclk(lclk), .i_nrst(nrst), .host_oe(i_sirq_if.host_oe),
        .host_o(i_sirq_if.host_o), .dev_oe(i_sirq_if.dev_oe), .dev_o(i_sirq_if.dev_o), .line(i_sirq_if.line));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction : xs

    // Frame 0 stays empty even when routed
    function automatic logic [15:0] expect_irq();
        logic [15:0] e;
        logic [SIRQ_ROUTE_W-1:0] r;
        e = 16'h0000;
        for (int f = 1; f < SIRQ_NFRAMES; f++) begin
            r = route[f*SIRQ_ROUTE_W +: SIRQ_ROUTE_W];
            if (r[SIRQ_ROUTE_EN_BIT]) e[f] = !src[r[SIRQ_SRC_W-1:0]];
            else if (f == SIRQ_SMI_FRAME) e[f] = !smi && !mask;
        end
        return e;
    endfunction : expect_irq

    task automatic fail(input string m);
        mismatches++;
        $display("ERROR %0t %s", $time, m);
    endtask : fail
    task automatic chk_irq(input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) fail($sformatf("frames %h expected %h", g, e));
    endtask : chk_irq
    task automatic chk_bit(input logic g, input logic e);
        num_checks++;
        if (g !== e) fail("status flag wrong");
    endtask : chk_bit
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    // ==========================================================================
    // Drivers, all at the falling edge
    task automatic wait_done(input int lim);
        int n;
        n = 0;
        while (done !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n == lim) fail("no result");
    endtask : wait_done
    task automatic settle;
        int n;
        n = 0;
        while (active !== 1'b0 && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (n == 500) fail("cycle never ends");
        repeat (40) @(negedge clk);
    endtask : settle
    // Run drops once the cycle is seen, so the host runs exactly one cycle
    task automatic cycle(input logic q);
        int n;
        n = 0;
        exp_q.push_back(expect_irq());
        qn = q;
        run = 1'b1;
        while (active !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        run = 1'b0;
        wait_done(2000);
        settle();
    endtask : cycle

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Sampled mid-cycle where outputs have settled; one result per done
    always @(negedge clk) begin
        done_q <= done;
        if (done === 1'b1 && done_q !== 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected result");
            else chk_irq(exp_q.pop_front(), irq_low);
        end
    end

    initial begin
        #500us;
        fail("timeout");
        results();
    end

    initial begin
        {nrst, run, qn, mask} = 4'h0;
        smi = 1'b1;
        src = '0;
        route = '0;
        seed = 32'h0000003e;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (20) @(negedge clk);
        chk_bit(quiet, 1'b0);
        cycle(1'b0);
        $display("test reset_default done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            src = seed;
            seed = xs(seed);
            smi = seed[30];
            mask = seed[31];
            for (int f = 0; f < SIRQ_NFRAMES; f++) route[f*SIRQ_ROUTE_W +: SIRQ_ROUTE_W] = {seed[f] | (f == 0), 5'(f + seed[20:16])};
            repeat (40) @(negedge clk);
            cycle(1'b0);
        end
        $display("test random_routing done");
        route[13*SIRQ_ROUTE_W +: SIRQ_ROUTE_W] = {1'b1, 5'h0d};
        repeat (40) @(negedge clk);
        cycle(1'b1);
        chk_bit(quiet, 1'b1);
        src[13] = !src[13];
        exp_q.push_back(expect_irq());
        wait_done(1000);
        settle();
        $display("test quiet_device_start done");
        cycle(1'b0);
        chk_bit(quiet, 1'b0);
        src[13] = !src[13];
        repeat (300) @(negedge clk);
        chk_bit(active, 1'b0);
        $display("test continuous_passive done");
        run = 1'b1;
        repeat (100) @(negedge clk);
        nrst = 1'b0;
        run = 1'b0;
        repeat (12) @(negedge clk);
        chk_bit(active, 1'b0);
        nrst = 1'b1;
        repeat (20) @(negedge clk);
        chk_bit(quiet, 1'b0);
        cycle(1'b0);
        $display("test mid_reset done");
        if (exp_q.size() != 0) fail("missing result");
        results();
    end
endmodule : tb_serial_irq_slave_agent
